// ### hdl/sct0_cfg.svh
`ifndef SCT0_CFG_SVH
`define SCT0_CFG_SVH
// Default rate factors when no TA1 was given
`define SCT0_FI_DEF 12'h174
`define SCT0_DI_DEF 7'h01
// Default wait integer when no TC2 was given
`define SCT0_WI_DEF 8'h0A
// Work waiting time multiplier (times wait integer times Fi)
`define SCT0_WWT_MULT 30'h3C0
// Etu indices inside one character
`define SCT0_LAST_BIT 4'h9
`define SCT0_ERR_IDX 4'hA
`define SCT0_CHK_IDX 4'hB
`define SCT0_RETRY_IDX 4'hD
// Command header length in bytes
`define SCT0_HDR_LEN 3'h5
// Procedure and status byte codes
`define SCT0_PB_NULL 8'h60
`define SCT0_SW1_MORE 8'h61
`define SCT0_SW1_RELEN 8'h6C
`define SCT0_GETRSP_INS 8'hC0
// Faulty answers in a row that reject the card
`define SCT0_ATR_TRIES 2'h3
`endif

// ### hdl/sct0_pkg.sv
package sct0_pkg;
  // Character engine states
  typedef enum logic [1:0] {
    CH_IDLE = 2'h0,
    CH_TX = 2'h1,
    CH_RX = 2'h2
  } sct0_ch_e;
  // Terminal command states
  typedef enum logic [2:0] {
    TM_IDLE = 3'h0,
    TM_HDR = 3'h1,
    TM_PROC = 3'h2,
    TM_WR = 3'h3,
    TM_RD = 3'h4,
    TM_SW2 = 3'h5
  } sct0_tm_e;
endpackage : sct0_pkg

// ### hdl/sct0_if.sv
// ****************************************
// Shared I/O line with pull-up
// ****************************************
interface sct0_if;
  logic term_o;    // Terminal drive level
  logic term_oe_n; // Terminal drives when low
  logic card_o;    // Card drive level
  logic card_oe_n; // Card drives when low
  logic io;        // Resolved line level
  // Any low driver wins, otherwise the pull-up holds the line high
  assign io = ~((~term_oe_n & ~term_o) | (~card_oe_n & ~card_o));
  modport term (output term_o, output term_oe_n, input io);
  modport card (output card_o, output card_oe_n, input io);
endinterface : sct0_if

// ### hdl/sct0_char.sv
`include "sct0_cfg.svh"
// ****************************************
// Character engine: one frame at a time
// ****************************************
module sct0_char (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] fi,
  input wire logic [6:0] di,
  input wire logic inv_conv,
  input wire logic low_imp,
  input wire logic perr_en,
  input wire logic hold_high,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_n,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic tx_done,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_perr,
  output logic start_seen
);
  sct0_pkg::sct0_ch_e st_r, st_nxt;
  logic [11:0] etu_r, etu_nxt, cnt_r, cnt_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [9:0] frm_r, frm_nxt; // Line levels of the frame
  logic err_r, err_nxt;
  logic s1_r, s2_r, s3_r, filt_r, filt_d_r, filt_nxt;
  logic lo_r, lo_nxt, hi_r, hi_nxt;
  logic rxv_nxt, perr_nxt, done_nxt, start_nxt;
  logic [7:0] rxd_nxt;
  logic etu_end, mid;
  logic [8:0] dec;

  // Byte to line levels; parity even over data plus parity
  function automatic logic [9:0] frame_of(input logic [7:0] d, input logic inv);
    logic [9:0] f;
    f[0] = 1'b0;
    for (int k = 0; k < 8; k++) f[k + 1] = inv ? ~d[7 - k] : d[k];
    f[9] = inv ? ~(^d) : ^d;
    return f;
  endfunction : frame_of

  // Line levels to {parity bad, byte}
  function automatic logic [8:0] byte_of(input logic [9:0] f, input logic inv);
    logic [7:0] d;
    logic p;
    for (int k = 0; k < 8; k++) d[k] = inv ? ~f[8 - k] : f[k + 1];
    p = inv ? ~f[9] : f[9];
    return {(^d) ^ p, d};
  endfunction : byte_of

  assign etu_end = (cnt_r == etu_r - 12'h001);
  assign mid = (cnt_r == {1'b0, etu_r[11:1]});
  assign dec = byte_of(frm_r, inv_conv);
  // Only start on a resting high line
  assign tx_ready = (st_r == sct0_pkg::CH_IDLE) && filt_r;
  assign line_o = ~lo_r;
  assign line_oe_n = ~(lo_r | hi_r);

  // Next state of the frame sequencer
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = etu_end ? 12'h000 : cnt_r + 12'h001;
    idx_nxt = etu_end ? idx_r + 4'h1 : idx_r;
    frm_nxt = frm_r;
    err_nxt = err_r;
    rxv_nxt = 1'b0;
    rxd_nxt = rx_data;
    perr_nxt = 1'b0;
    done_nxt = 1'b0;
    start_nxt = 1'b0;
    // Etu is Fi over Di card clocks, defaults if zero
    etu_nxt = 12'((fi == 12'h000 ? `SCT0_FI_DEF : fi) / 
      (di == 7'h00 ? `SCT0_DI_DEF : di));
    // A change counts once the last two stages agree
    filt_nxt = (s2_r == s3_r) ? s3_r : filt_r;
    unique case (st_r)
      sct0_pkg::CH_IDLE: begin
        cnt_nxt = 12'h000;
        idx_nxt = 4'h0;
        err_nxt = 1'b0;
        if (tx_valid && tx_ready) begin
          frm_nxt = frame_of(tx_data, inv_conv);
          st_nxt = sct0_pkg::CH_TX;
          start_nxt = 1'b1;
        end else if (filt_d_r && !filt_r) begin
          st_nxt = sct0_pkg::CH_RX;
          start_nxt = 1'b1;
        end
      end
      sct0_pkg::CH_TX: begin
        // Error indication checked at 11 etu
        if (idx_r == `SCT0_CHK_IDX && cnt_r == 12'h000 && perr_en && !filt_r) begin
          err_nxt = 1'b1;
        end
        if (etu_end && idx_r == `SCT0_CHK_IDX && !err_r) begin
          st_nxt = sct0_pkg::CH_IDLE;
          done_nxt = 1'b1;
        end else if (etu_end && idx_r == `SCT0_RETRY_IDX) begin
          idx_nxt = 4'h0; // Resend 3 etu after the check
          err_nxt = 1'b0;
          start_nxt = 1'b1;
        end
      end
      sct0_pkg::CH_RX: begin
        if (mid && idx_r <= `SCT0_LAST_BIT) begin
          frm_nxt[idx_r] = filt_r;
          if (idx_r == 4'h0 && filt_r) begin
            st_nxt = sct0_pkg::CH_IDLE; // Glitch, not a start bit
          end
        end
        if (mid && idx_r == `SCT0_ERR_IDX) begin
          rxd_nxt = dec[7:0];
          perr_nxt = dec[8];
          err_nxt = dec[8] && perr_en;
          rxv_nxt = !(dec[8] && perr_en);
        end
        // Listen until 12 etu so a reply keeps the spacing
        if (etu_end && idx_r == `SCT0_CHK_IDX) begin
          st_nxt = sct0_pkg::CH_IDLE;
        end
      end
      default: st_nxt = sct0_pkg::CH_IDLE;
    endcase
    // Drive low for bits and error pulse, high only in low impedance
    lo_nxt = ((st_r == sct0_pkg::CH_TX) && idx_r <= `SCT0_LAST_BIT && !frm_r[idx_r])
      || ((st_r == sct0_pkg::CH_RX) && err_r);
    hi_nxt = low_imp && ((((st_r == sct0_pkg::CH_TX) && idx_r <= `SCT0_LAST_BIT
      && frm_r[idx_r])) || ((st_r == sct0_pkg::CH_IDLE) && hold_high));
  end

  // Registers of the frame sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= sct0_pkg::CH_IDLE;
      etu_r <= `SCT0_FI_DEF;
      cnt_r <= 12'h000;
      idx_r <= 4'h0;
      frm_r <= 10'h3FF;
      err_r <= 1'b0;
      {s1_r, s2_r, s3_r, filt_r, filt_d_r} <= 5'h1F;
      {lo_r, hi_r} <= 2'h0;
      {rx_valid, rx_perr, tx_done, start_seen} <= 4'h0;
      rx_data <= 8'h00;
    end else begin
      st_r <= st_nxt;
      etu_r <= etu_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      frm_r <= frm_nxt;
      err_r <= err_nxt;
      {s1_r, s2_r, s3_r} <= {line_i, s1_r, s2_r};
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
      {lo_r, hi_r} <= {lo_nxt, hi_nxt};
      {rx_valid, rx_perr, tx_done, start_seen} <= {rxv_nxt, perr_nxt, done_nxt, start_nxt};
      rx_data <= rxd_nxt;
    end
  end
endmodule : sct0_char

// ### hdl/sct0_card.sv
`include "sct0_cfg.svh"
// ****************************************
// Card end of the character link
// ****************************************
module sct0_card (
  input wire logic CLK,
  input wire logic RST_N,
  sct0_if.card LINK,
  input wire logic [11:0] FI_VAL,
  input wire logic [6:0] DI_VAL,
  input wire logic [7:0] WI_VAL,
  input wire logic INV_CONV,
  input wire logic LOW_IMP,
  output logic HDR_VALID,
  output logic [39:0] HDR_DATA,
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST
);
  logic busy_r, busy_nxt;     // Header taken, card's turn
  logic [2:0] hcnt_r, hcnt_nxt;
  logic [39:0] hdr_nxt;
  logic sent_r, sent_nxt, nul_ok_r, nul_ok_nxt, last_r, last_nxt;
  logic [29:0] wcnt_r, wcnt_nxt, lim_r, lim_nxt;
  logic hv_nxt, take, use_null;
  logic tx_ready, tx_done, rx_valid, rx_perr, start_seen;
  logic [7:0] rx_data;

  // Null answer only while no procedure byte went out yet
  assign use_null = nul_ok_r && (wcnt_r >= {1'b0, lim_r[29:1]});
  assign take = (TX_VALID || use_null) && !sent_r && tx_ready;
  assign TX_READY = take && !use_null;
  assign RX_VALID = rx_valid && busy_r;
  assign RX_DATA = rx_data;

  sct0_char u_char (
    .clk(CLK),
    .rst_n(RST_N),
    .fi(FI_VAL),
    .di(DI_VAL),
    .inv_conv(INV_CONV),
    .low_imp(LOW_IMP),
    .perr_en(1'b1),
    .hold_high(busy_r),
    .line_i(LINK.io),
    .line_o(LINK.card_o),
    .line_oe_n(LINK.card_oe_n),
    .tx_valid((TX_VALID || use_null) && !sent_r),
    .tx_ready(tx_ready),
    .tx_data(use_null ? `SCT0_PB_NULL : TX_DATA),
    .tx_done(tx_done),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_perr(rx_perr),
    .start_seen(start_seen)
  );

  // Header collection, turn tracking and wait supervision
  always_comb begin
    busy_nxt = busy_r;
    hcnt_nxt = hcnt_r;
    hdr_nxt = HDR_DATA;
    hv_nxt = 1'b0;
    sent_nxt = (sent_r || take) && !tx_done;
    last_nxt = take ? (TX_LAST && !use_null) : last_r;
    nul_ok_nxt = nul_ok_r && !(take && !use_null);
    wcnt_nxt = start_seen ? 30'h0 : wcnt_r + 30'h1;
    lim_nxt = `SCT0_WWT_MULT * 30'(WI_VAL == 8'h00 ? `SCT0_WI_DEF : WI_VAL)
      * 30'(FI_VAL == 12'h000 ? `SCT0_FI_DEF : FI_VAL);
    if (!busy_r && rx_valid) begin
      hdr_nxt = {HDR_DATA[31:0], rx_data}; // First byte lands on top
      hcnt_nxt = hcnt_r + 3'h1;
      if (hcnt_r == `SCT0_HDR_LEN - 3'h1) begin
        hcnt_nxt = 3'h0;
        busy_nxt = 1'b1;
        hv_nxt = 1'b1;
        nul_ok_nxt = 1'b1; // Header in: an answer is owed
      end
    end
    // Status word sent: back to waiting for a header
    if (tx_done && last_r) begin
      busy_nxt = 1'b0;
      nul_ok_nxt = 1'b0;
    end
  end

  // Registers of the card end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_r <= 1'b0;
      hcnt_r <= 3'h0;
      HDR_DATA <= 40'h0;
      HDR_VALID <= 1'b0;
      {sent_r, nul_ok_r, last_r} <= 3'h0;
      wcnt_r <= 30'h0;
      lim_r <= 30'h0;
    end else begin
      busy_r <= busy_nxt;
      hcnt_r <= hcnt_nxt;
      HDR_DATA <= hdr_nxt;
      HDR_VALID <= hv_nxt;
      {sent_r, nul_ok_r, last_r} <= {sent_nxt, nul_ok_nxt, last_nxt};
      wcnt_r <= wcnt_nxt;
      lim_r <= lim_nxt;
    end
  end
endmodule : sct0_card

// ### hdl/sct0_term.sv
`include "sct0_cfg.svh"

// ****************************************
// Terminal end of the character link
// ****************************************
module sct0_term (
  input wire logic CLK,
  input wire logic RST_N,
  sct0_if.term LINK,
  input wire logic [11:0] FI_VAL,
  input wire logic [6:0] DI_VAL,
  input wire logic [7:0] WI_VAL,
  input wire logic INV_CONV,
  input wire logic LOW_IMP,
  input wire logic ATR_PHASE,
  input wire logic CLK_STOPPED,
  input wire logic ATR_FAULT,
  input wire logic ATR_OK,
  output logic RESET_REQ,
  output logic CARD_REJECT,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [39:0] CMD_HDR,
  input wire logic CMD_WR,
  input wire logic WR_VALID,
  output logic WR_READY,
  input wire logic [7:0] WR_DATA,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic SW_VALID,
  output logic [15:0] SW_DATA,
  output logic WWT_EXPIRED,
  output logic PROTO_ERR
);
  // ****************************************
  // Declarations
  // ****************************************
  sct0_pkg::sct0_tm_e st_r, st_nxt;
  logic [39:0] hdr_r, hdr_nxt;     // Header kept for a resend
  logic [39:0] sh_r, sh_nxt;       // Header bytes still to send
  logic [2:0] hidx_r, hidx_nxt;
  logic wr_r, wr_nxt;              // Data goes to the card
  logic one_r, one_nxt;            // Single byte transfer
  logic [8:0] rem_r, rem_nxt;      // Data bytes left
  logic [7:0] sw1_r, sw1_nxt;
  logic sent_r, sent_nxt;          // Byte handed to the engine
  logic [29:0] wcnt_r, wcnt_nxt, lim_r, lim_nxt;
  logic [1:0] fails_r, fails_nxt;
  logic rej_nxt, rst_nxt, rdv_nxt, swv_nxt, exp_nxt, perr_nxt;
  logic [7:0] rdd_nxt;
  logic [15:0] sw_nxt;
  logic waiting, my_turn, tx_valid, take;
  logic [7:0] tx_data, pb;
  logic tx_ready, tx_done, rx_valid, rx_perr, start_seen;
  logic [7:0] rx_data;

  // ****************************************
  // Engine hookup
  // ****************************************
  // Card owes us characters in these states
  assign waiting = (st_r == sct0_pkg::TM_PROC) || (st_r == sct0_pkg::TM_RD)
    || (st_r == sct0_pkg::TM_SW2);
  // Our turn to send, or the clock is stopped
  assign my_turn = CLK_STOPPED || (!ATR_PHASE && !waiting);
  assign tx_valid = !sent_r && ((st_r == sct0_pkg::TM_HDR)
    || (st_r == sct0_pkg::TM_WR && WR_VALID && rem_r != 9'h000));
  assign tx_data = (st_r == sct0_pkg::TM_HDR) ? sh_r[39:32] : WR_DATA;
  assign take = tx_valid && tx_ready;
  assign WR_READY = take && (st_r == sct0_pkg::TM_WR);
  assign CMD_READY = (st_r == sct0_pkg::TM_IDLE) && !CARD_REJECT;
  assign pb = rx_data;

  // Shared frame engine; a stopped clock also holds the line high here in low impedance
  sct0_char u_char (
    .clk(CLK),
    .rst_n(RST_N),
    .fi(FI_VAL),
    .di(DI_VAL),
    .inv_conv(INV_CONV),
    .low_imp(LOW_IMP),
    .perr_en(!ATR_PHASE),
    .hold_high(my_turn),
    .line_i(LINK.io),
    .line_o(LINK.term_o),
    .line_oe_n(LINK.term_oe_n),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx_data(tx_data),
    .tx_done(tx_done),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_perr(rx_perr),
    .start_seen(start_seen)
  );

  // ****************************************
  // Command sequencer
  // ****************************************
  // Walks header, procedure bytes, data and status
  always_comb begin
    st_nxt = st_r;
    hdr_nxt = hdr_r;
    sh_nxt = sh_r;
    hidx_nxt = hidx_r;
    wr_nxt = wr_r;
    one_nxt = one_r;
    rem_nxt = rem_r;
    sw1_nxt = sw1_r;
    sent_nxt = (sent_r || take) && !tx_done;
    rdv_nxt = 1'b0;
    rdd_nxt = RD_DATA;
    swv_nxt = 1'b0;
    sw_nxt = SW_DATA;
    exp_nxt = 1'b0;
    perr_nxt = 1'b0;
    unique case (st_r)
      sct0_pkg::TM_IDLE: begin
        // Answer-to-reset bytes pass straight up
        if (rx_valid) begin
          rdv_nxt = 1'b1;
          rdd_nxt = rx_data;
        end
        if (CMD_VALID && CMD_READY) begin
          hdr_nxt = CMD_HDR;
          sh_nxt = CMD_HDR;
          wr_nxt = CMD_WR;
          st_nxt = sct0_pkg::TM_HDR;
        end
      end
      sct0_pkg::TM_HDR: begin
        // Five bytes, CLA first
        if (tx_done) begin
          sh_nxt = {sh_r[31:0], 8'h00};
          hidx_nxt = hidx_r + 3'h1;
          if (hidx_r == `SCT0_HDR_LEN - 3'h1) begin
            hidx_nxt = 3'h0;
            // Zero length on a read means 256 bytes
            rem_nxt = (hdr_r[7:0] == 8'h00 && !wr_r) ? 9'h100 : {1'b0, hdr_r[7:0]};
            st_nxt = sct0_pkg::TM_PROC;
          end
        end
      end
      sct0_pkg::TM_PROC: begin
        if (rx_valid) begin
          if (pb == `SCT0_PB_NULL) begin
            st_nxt = sct0_pkg::TM_PROC; // Wait on, count restarts
          end else if (pb == hdr_r[31:24] || pb == ~hdr_r[31:24]) begin
            // Never passed up as data
            one_nxt = (pb != hdr_r[31:24]);
            st_nxt = wr_r ? sct0_pkg::TM_WR : sct0_pkg::TM_RD;
          end else if (pb[7:4] == 4'h6 || pb[7:4] == 4'h9) begin
            sw1_nxt = pb;
            st_nxt = sct0_pkg::TM_SW2;
          end else begin
            perr_nxt = 1'b1; // Unknown byte: abandon the command
            st_nxt = sct0_pkg::TM_IDLE;
          end
        end
      end
      sct0_pkg::TM_WR: begin
        // Nothing left: the card owes a status
        if (rem_r == 9'h000) begin
          st_nxt = sct0_pkg::TM_PROC;
        end else if (tx_done) begin
          rem_nxt = rem_r - 9'h001;
          if (one_r || rem_r == 9'h001) begin
            st_nxt = sct0_pkg::TM_PROC;
          end
        end
      end
      sct0_pkg::TM_RD: begin
        if (rem_r == 9'h000) begin
          st_nxt = sct0_pkg::TM_PROC;
        end else if (rx_valid) begin
          rdv_nxt = 1'b1;
          rdd_nxt = rx_data;
          rem_nxt = rem_r - 9'h001;
          if (one_r || rem_r == 9'h001) begin
            st_nxt = sct0_pkg::TM_PROC;
          end
        end
      end
      sct0_pkg::TM_SW2: begin
        if (rx_valid) begin
          if (sw1_r == `SCT0_SW1_MORE) begin
            // Fetch the pending answer, length from the second byte
            hdr_nxt = {hdr_r[39:32], `SCT0_GETRSP_INS, 16'h0000, rx_data};
            sh_nxt = hdr_nxt;
            wr_nxt = 1'b0;
            st_nxt = sct0_pkg::TM_HDR;
          end else if (sw1_r == `SCT0_SW1_RELEN) begin
            // Same command again at once with corrected length
            hdr_nxt = {hdr_r[39:8], rx_data};
            sh_nxt = hdr_nxt;
            st_nxt = sct0_pkg::TM_HDR;
          end else begin
            swv_nxt = 1'b1;
            sw_nxt = {sw1_r, rx_data};
            st_nxt = sct0_pkg::TM_IDLE;
          end
        end
      end
      default: st_nxt = sct0_pkg::TM_IDLE;
    endcase
    // Card silent too long: ask for deactivation at once
    if (waiting && wcnt_r >= lim_r) begin
      exp_nxt = 1'b1;
      st_nxt = sct0_pkg::TM_IDLE;
    end
  end

  // Registers of the command sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= sct0_pkg::TM_IDLE;
      hdr_r <= 40'h0;
      sh_r <= 40'h0;
      hidx_r <= 3'h0;
      {wr_r, one_r, sent_r} <= 3'h0;
      rem_r <= 9'h000;
      sw1_r <= 8'h00;
      {RD_VALID, SW_VALID, WWT_EXPIRED, PROTO_ERR} <= 4'h0;
      RD_DATA <= 8'h00;
      SW_DATA <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      hdr_r <= hdr_nxt;
      sh_r <= sh_nxt;
      hidx_r <= hidx_nxt;
      {wr_r, one_r, sent_r} <= {wr_nxt, one_nxt, sent_nxt};
      rem_r <= rem_nxt;
      sw1_r <= sw1_nxt;
      {RD_VALID, SW_VALID, WWT_EXPIRED, PROTO_ERR} <= {rdv_nxt, swv_nxt, exp_nxt, perr_nxt};
      RD_DATA <= rdd_nxt;
      SW_DATA <= sw_nxt;
    end
  end

  // ****************************************
  // Wait supervision and answer-to-reset retries
  // ****************************************
  // Count only while waiting, restarting at every character start
  always_comb begin
    wcnt_nxt = (start_seen || !waiting) ? 30'h0 : wcnt_r + 30'h1;
    lim_nxt = `SCT0_WWT_MULT * 30'(WI_VAL == 8'h00 ? `SCT0_WI_DEF : WI_VAL)
      * 30'(FI_VAL == 12'h000 ? `SCT0_FI_DEF : FI_VAL);
    fails_nxt = ATR_OK ? 2'h0 : fails_r;
    rej_nxt = CARD_REJECT;
    rst_nxt = 1'b0;
    // A fault in the same cycle as a good answer still counts
    if (ATR_FAULT && !CARD_REJECT) begin
      fails_nxt = fails_r + 2'h1;
      if (fails_r == `SCT0_ATR_TRIES - 2'h1) begin
        rej_nxt = 1'b1;
      end else begin
        rst_nxt = 1'b1;
      end
    end
  end

  // Registers of supervision
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wcnt_r <= 30'h0;
      lim_r <= 30'h0;
      fails_r <= 2'h0;
      CARD_REJECT <= 1'b0;
      RESET_REQ <= 1'b0;
    end else begin
      wcnt_r <= wcnt_nxt;
      lim_r <= lim_nxt;
      fails_r <= fails_nxt;
      CARD_REJECT <= rej_nxt;
      RESET_REQ <= rst_nxt;
    end
  end
endmodule : sct0_term

// ### tb/sct0_link_properties.sv
// ******************************
// Shared line timing checks
// ******************************
module sct0_link_properties #(parameter int ETU = 16) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic term_o,
  input wire logic term_oe_n,
  input wire logic card_o,
  input wire logic card_oe_n,
  input wire logic io
);
  logic io_q; // Line one cycle ago
  logic err_r; // Error pull seen in this frame
  logic [15:0] n_r; // Cycles since start edge, saturating
  logic fall_w; // Line fell this cycle
  logic start_w; // Falls past the error window open a frame
  logic errf_w; // Falls inside the window are error pulls
  assign fall_w = io_q & ~io;
  assign start_w = fall_w && n_r >= 11 * ETU;
  assign errf_w = fall_w && n_r >= 10 * ETU && n_r < 11 * ETU;
  // Frame position, restarted at each start edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_q <= 1'b1;
      err_r <= 1'b0;
      n_r <= 16'hFFFF;
    end else begin
      io_q <= io;
      err_r <= !start_w && (err_r || errf_w);
      n_r <= start_w ? 16'h0001 : n_r + 16'(n_r != 16'hFFFF);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Pull held at least half an etu, line free again one to two etu after it fell
  sequence pull_then_free;
    !io [*8] ##[8:24] io;
  endsequence
  drive_clash_a: assert property (term_oe_n || card_oe_n || term_o == card_o)
    else $error("Opposite drivers");
  start_bit_a: assert property (start_w |=> !io [*8])
    else $error("Short start bit");
  start_gap_a: assert property (start_w |-> n_r >= 12 * ETU)
    else $error("Starts too close");
  retry_gap_a: assert property (start_w && err_r |-> n_r >= 13 * ETU)
    else $error("Early repeat");
  guard_free_a: assert property (n_r > 10 * ETU + 1 && n_r < 10 * ETU + 7 |-> io)
    else $error("Guard not released");
  bit_hold_a: assert property (n_r < 10 * ETU && n_r % ETU inside {[3:12]} |-> $stable(io))
    else $error("Bit changed mid etu");
  err_start_a: assert property (errf_w |-> n_r >= 10 * ETU + ETU / 2)
    else $error("Early error pull");
  err_len_a: assert property (errf_w |=> pull_then_free)
    else $error("Bad error pull length");
endmodule : sct0_link_properties

// ### tb/smartcard_t0_char_link_tb_top.sv
module smartcard_t0_char_link_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic inv; logic low; logic [39:0] hdr; logic [15:0] sw;} sct0_row_s;
  // Convention, drive mode, header and direct status answer
  localparam sct0_row_s ROWS [3] = '{'{1'b0, 1'b0, 40'h00A4000002, 16'h9000},
    '{1'b1, 1'b1, 40'h80F2000010, 16'h6A82}, '{1'b0, 1'b1, 40'hA0A4000402, 16'h9F10}};
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [11:0] FI_VAL = 12'h010; // Etu of 16 cycles keeps the run short
  logic [6:0] DI_VAL = 7'h01;
  logic [7:0] WI_VAL = 8'h01;
  logic INV_CONV = 1'b0, LOW_IMP = 1'b0, ATR_PHASE = 1'b0, CLK_STOPPED = 1'b0;
  logic ATR_FAULT = 1'b0, ATR_OK = 1'b0, CMD_VALID = 1'b0, CMD_WR = 1'b0, WR_VALID = 1'b0;
  logic TX_VALID = 1'b0, TX_LAST = 1'b0;
  logic [39:0] CMD_HDR = 40'h0;
  logic [7:0] WR_DATA = 8'h00, TX_DATA = 8'h00;
  logic RESET_REQ, CARD_REJECT, CMD_READY, WR_READY, RD_VALID, SW_VALID, WWT_EXPIRED;
  logic PROTO_ERR, HDR_VALID, RX_VALID, TX_READY;
  logic [39:0] HDR_DATA;
  logic [7:0] RD_DATA, RX_DATA;
  logic [15:0] SW_DATA;
  logic [43:0] evq [$]; // Output events in order, kind in the top nibble
  int err_count = 0, samples_checked = 0, cyc = 0;
  always #2.5 CLK = ~CLK;
  sct0_if sct0_if_i ();
  sct0_term sct0_term_i (.LINK(sct0_if_i.term), .*);
  sct0_card sct0_card_i (.LINK(sct0_if_i.card), .*);
  sct0_link_properties #(.ETU(16)) sct0_link_properties_i (.clk(CLK), .rst_n(RST_N),
    .term_o(sct0_if_i.term_o), .term_oe_n(sct0_if_i.term_oe_n), .card_o(sct0_if_i.card_o),
    .card_oe_n(sct0_if_i.card_oe_n), .io(sct0_if_i.io));
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Wait for the next output event and compare it
  task automatic ev(input logic [43:0] exp);
    while (evq.size() == 0) @(negedge CLK);
    chk(evq.pop_front(), exp);
  endtask : ev
  // Card offers one byte and holds it until taken
  task automatic cs(input logic [7:0] d, input logic last);
    @(negedge CLK);
    TX_VALID = 1'b1;
    TX_DATA = d;
    TX_LAST = last;
    while (TX_READY !== 1'b1) @(negedge CLK);
    @(negedge CLK);
    TX_VALID = 1'b0;
  endtask : cs
  // Terminal command request, held until accepted
  task automatic cmd(input logic [39:0] h);
    @(negedge CLK);
    CMD_VALID = 1'b1;
    CMD_HDR = h;
    while (CMD_READY !== 1'b1) @(negedge CLK);
    @(negedge CLK);
    CMD_VALID = 1'b0;
  endtask : cmd
  // One-cycle answer-to-reset verdict
  task automatic atr(input logic ok);
    @(negedge CLK);
    ATR_OK = ok;
    ATR_FAULT = !ok;
    @(negedge CLK);
    {ATR_OK, ATR_FAULT} = 2'h0;
  endtask : atr
  // Log output events; a hung run counts as a mismatch
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (HDR_VALID) evq.push_back({4'h1, HDR_DATA});
    if (RD_VALID) evq.push_back({4'h2, 32'h0, RD_DATA});
    if (SW_VALID) evq.push_back({4'h3, 24'h0, SW_DATA});
    if (RESET_REQ) evq.push_back(44'h50000000000);
    if (WWT_EXPIRED || PROTO_ERR) evq.push_back(44'h60000000000);
    if (cyc == 40000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    repeat (4) @(negedge CLK);
    foreach (ROWS[i]) begin
      INV_CONV = ROWS[i].inv;
      LOW_IMP = ROWS[i].low;
      cmd(ROWS[i].hdr);
      ev({4'h1, ROWS[i].hdr});
      cs(ROWS[i].sw[15:8], 1'b0);
      cs(ROWS[i].sw[7:0], 1'b1);
      ev({4'h3, 24'h0, ROWS[i].sw});
      $display("Row %0d done", i);
    end
    // Null byte, then ack for all remaining bytes
    cmd(40'h00B0000002);
    ev(44'h100B0000002);
    cs(8'h60, 1'b0);
    cs(8'hB0, 1'b0);
    cs(8'h11, 1'b0);
    cs(8'h22, 1'b0);
    cs(8'h90, 1'b0);
    cs(8'h00, 1'b1);
    ev(44'h20000000011);
    ev(44'h20000000022);
    ev(44'h30000009000);
    $display("Null and ack test done");
    // Single-byte ack, then more-data and wrong-length answers
    cmd(40'h00B2000001);
    ev(44'h100B2000001);
    cs(8'h4D, 1'b0);
    cs(8'h33, 1'b0);
    cs(8'h61, 1'b0);
    cs(8'h05, 1'b1);
    ev(44'h20000000033);
    ev(44'h100C0000005);
    cs(8'h6C, 1'b0);
    cs(8'h03, 1'b1);
    ev(44'h100C0000003);
    cs(8'h90, 1'b0);
    cs(8'h00, 1'b1);
    ev(44'h30000009000);
    $display("Response fetch test done");
    // Faulty answers: a good one breaks the run of three
    atr(1'b0);
    atr(1'b1);
    atr(1'b0);
    atr(1'b0);
    chk(44'(CARD_REJECT), 44'h0);
    atr(1'b0);
    @(negedge CLK);
    chk(44'({CARD_REJECT, CMD_READY}), 44'h2);
    repeat (3) ev(44'h50000000000);
    chk(44'(evq.size()), 44'h0);
    $display("Answer fault test done");
    conclude();
  end
endmodule : smartcard_t0_char_link_tb_top
